// File: design/epc_cycle_engine.sv
// enhanced parallel port 1.7 cycle engine
`include "epc_map.svh"
`default_nettype none

// Summary of operation
// - write stretched while peripheral wait low
// - write ends when wait seen high or on timeout
// - write drives byte no later than its strobe
// - strobed write stretched until wait or timeout
// - write end: ready sync, strobe off, byte held
// - read strobe only with drivers off, bit set
// - strobed read stretched until wait or timeout
// - read end: byte with ready sync, strobe off
// - interrupt passed through, no inversion
// - active-low peripheral reset output
// - address strobe for address, data strobe data
// - write-direction output and bus drivers overridable by strobe
// - watchdog aborts after 10 us, status bit 0
// - data offsets strobe only in enhanced mode
module epc_cycle_engine
    import epc_pkg::*;
(
    // clock and reset
    input  wire logic      clk_i,
    input  wire logic      arst_n_i,
    // host side
    input  wire epc_req_t  host_req_i,
    output epc_resp_t      host_resp_o,
    output logic           host_wait_o,
    // control and status
    input  wire logic      epp_mode_i,
    input  wire logic      bus_direction_bit_i,
    input  wire logic      spp_strobe_i,
    input  wire logic      periph_init_ctl_i,
    input  wire logic      timeout_clr_i,
    output logic [7:0]     status_o,
    // peripheral side
    input  wire logic [7:0] par_bus_in_i,
    output logic [7:0]     par_bus_out_o,
    output logic           par_bus_oe_o,
    output logic           dir_out_low_o,
    output logic           data_strobe_n_o,
    output logic           addr_strobe_n_o,
    input  wire logic      periph_wait_n_i,
    input  wire logic      periph_interrupt_i,
    output logic           periph_interrupt_o,
    output logic           periph_init_n_o,
    input  wire logic      paper_out_status_i,
    input  wire logic      selected_status_i,
    input  wire logic      fault_status_n_i
);

    // ******************************************
    // decode
    // ******************************************
    function automatic logic is_data_ofs(input logic [2:0] ofs);
        is_data_ofs = (ofs >= `EPC_OFS_DATA0) && (ofs <= `EPC_OFS_DATA3);
    endfunction : is_data_ofs

    epc_state_t state_reg;
    epc_state_t state_next;
    logic       xfer_addr_reg;
    logic       timeout_reg;
    logic       expired;

    wire req_data   = host_req_i.valid && is_data_ofs(host_req_i.offset) && epp_mode_i;
    wire req_addr   = host_req_i.valid && (host_req_i.offset == `EPC_OFS_ADDR) && epp_mode_i;
    wire req_xfer   = req_data || req_addr;
    wire req_other  = host_req_i.valid && !req_xfer;
    // drivers on whenever direction bit clear or strobe override
    wire drive_next = !bus_direction_bit_i || spp_strobe_i;
    // strobe allowed once drivers already on or direction bit set
    wire can_strobe = par_bus_oe_o || bus_direction_bit_i;
    wire periph_ok  = periph_wait_n_i;
    wire finish     = (state_reg == EPC_STROBE) && (periph_ok || expired);
    wire abort_prep = (state_reg == EPC_PREP) && expired;
    wire end_cycle  = finish || abort_prep;

    // ******************************************
    // sequencer
    // ******************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            EPC_IDLE: begin
                if (req_xfer) begin
                    state_next = can_strobe ? EPC_STROBE : EPC_PREP;
                end
            end
            EPC_PREP: begin
                if (expired) begin
                    state_next = EPC_IDLE;
                end else if (can_strobe) begin
                    state_next = EPC_STROBE;
                end
            end
            EPC_STROBE: begin
                if (finish) begin
                    state_next = EPC_IDLE;
                end
            end
            default: begin
                state_next = EPC_IDLE;
            end
        endcase
    end

    epc_wdog u_wdog (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .run_i     (state_reg != EPC_IDLE),
        .expired_o (expired)
    );

    wire strobe_next = (state_next == EPC_STROBE);
    wire start_xfer  = (state_reg == EPC_IDLE) && req_xfer;
    wire xfer_write  = par_bus_oe_o;
    wire to_set      = end_cycle && expired;

    // ******************************************
    // registers
    // ******************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg     <= EPC_IDLE;
            xfer_addr_reg <= 1'b0;
            timeout_reg   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            xfer_addr_reg <= start_xfer ? req_addr : xfer_addr_reg;
            timeout_reg   <= to_set || (timeout_reg && !timeout_clr_i);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            par_bus_out_o   <= `EPC_RST_BYTE;
            par_bus_oe_o    <= 1'b0;
            dir_out_low_o   <= 1'b1;
            data_strobe_n_o <= 1'b1;
            addr_strobe_n_o <= 1'b1;
        end else begin
            // byte latched at request and held past the strobe
            if (start_xfer && host_req_i.write) begin
                par_bus_out_o <= host_req_i.wdata;
            end
            par_bus_oe_o    <= drive_next;
            dir_out_low_o   <= !drive_next;
            data_strobe_n_o <= !(strobe_next && (start_xfer ? req_data : !xfer_addr_reg));
            addr_strobe_n_o <= !(strobe_next && (start_xfer ? req_addr : xfer_addr_reg));
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            host_resp_o <= '0;
            host_wait_o <= 1'b0;
        end else begin
            host_resp_o.done    <= end_cycle || ((state_reg == EPC_IDLE) && req_other);
            host_resp_o.timeout <= end_cycle && expired;
            if (finish && !xfer_write) begin
                host_resp_o.rdata <= par_bus_in_i;
            end else if (req_other) begin
                host_resp_o.rdata <= 8'hff;
            end
            host_wait_o <= (state_next != EPC_IDLE);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            periph_interrupt_o <= 1'b0;
            periph_init_n_o    <= 1'b0;
            status_o           <= `EPC_RST_STATUS;
        end else begin
            periph_interrupt_o                <= periph_interrupt_i;
            periph_init_n_o                   <= !periph_init_ctl_i;
            status_o                          <= '0;
            status_o[`EPC_ST_TIMEOUT]         <= to_set || (timeout_reg && !timeout_clr_i);
            status_o[`EPC_ST_FAULT_N]         <= fault_status_n_i;
            status_o[`EPC_ST_SELECTED]        <= selected_status_i;
            status_o[`EPC_ST_PAPER_OUT]       <= paper_out_status_i;
            status_o[`EPC_ST_PERIPH_INTERRUPT]            <= periph_interrupt_i;
        end
    end

    // ******************************************
    // assertions
    // ******************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_addr_strobe_kind: assert property (!addr_strobe_n_o |-> xfer_addr_reg)
        else $error("address strobe during data transfer");
    a_data_strobe_kind: assert property (!data_strobe_n_o |-> !xfer_addr_reg)
        else $error("data strobe during address transfer");
    a_stretch_on_wait: assert property (
        (state_reg == EPC_STROBE && !periph_wait_n_i && !expired) |=> host_wait_o && !host_resp_o.done)
        else $error("cycle not stretched while wait low");
    a_finish_on_wait: assert property (
        (host_resp_o.done && !host_resp_o.timeout && $past(state_reg) == EPC_STROBE)
        |-> $past(periph_wait_n_i))
        else $error("transfer ended without wait high");
    a_read_drv_off: assert property (
        $fell(data_strobe_n_o) && !par_bus_oe_o |-> $past(bus_direction_bit_i))
        else $error("read strobe without direction bit");
    a_done_strobe_off: assert property (host_resp_o.done |-> data_strobe_n_o && addr_strobe_n_o)
        else $error("strobe still active at final sync");
    a_write_byte_hold: assert property (
        (!data_strobe_n_o && par_bus_oe_o) ##1 data_strobe_n_o |-> $stable(par_bus_out_o))
        else $error("output byte changed at write end");
    // expired stays high one cycle past the abort, so only its first cycle counts
    a_abort_reports: assert property (
        $rose(expired) |=> host_resp_o.done && host_resp_o.timeout ##1 status_o[0])
        else $error("timeout not reported");
    a_irq_pass: assert property (##1 periph_interrupt_o == $past(periph_interrupt_i))
        else $error("interrupt not passed through");
    a_dir_override: assert property (spp_strobe_i |=> !dir_out_low_o ##0 par_bus_oe_o)
        else $error("strobe override lost");

    c_write_xfer: cover property (!data_strobe_n_o && par_bus_oe_o ##[1:20] host_resp_o.done);
    c_read_xfer: cover property (!data_strobe_n_o && !par_bus_oe_o ##[1:20] host_resp_o.done);
    c_addr_xfer: cover property (!addr_strobe_n_o ##[1:20] host_resp_o.done);
    c_timeout: cover property (host_resp_o.timeout);

endmodule : epc_cycle_engine

`default_nettype wire

// File: design/epc_map.svh
// constants of the parallel port cycle engine
`ifndef EPC_MAP_SVH
`define EPC_MAP_SVH

// host offsets from the port base
`define EPC_OFS_ADDR      3'h3
`define EPC_OFS_DATA0     3'h4
`define EPC_OFS_DATA3     3'h7

// status byte layout
`define EPC_ST_TIMEOUT    0
`define EPC_ST_FAULT_N    3
`define EPC_ST_SELECTED   4
`define EPC_ST_PAPER_OUT  5
`define EPC_ST_PERIPH_INTERRUPT       6

// reset values
`define EPC_RST_BYTE      8'h00
`define EPC_RST_STATUS    8'h00

// watchdog timing
`define EPC_TIMEOUT_NS    10000
`define EPC_CLK_NS        8
`define EPC_WDOG_CYCLES   (`EPC_TIMEOUT_NS / `EPC_CLK_NS)
`define EPC_WDOG_W        11

`endif

// File: design/epc_pkg.sv
// types of the parallel port cycle engine
`default_nettype none

package epc_pkg;

    // host i/o request, valid for one cycle
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [2:0] offset;
        logic [7:0] wdata;
    } epc_req_t;

    // host answer: final ready sync with data
    typedef struct packed {
        logic       done;
        logic       timeout;
        logic [7:0] rdata;
    } epc_resp_t;

    typedef enum logic [1:0] {
        EPC_IDLE,
        EPC_PREP,
        EPC_STROBE
    } epc_state_t;

endpackage : epc_pkg

`default_nettype wire

// File: design/epc_wdog.sv
// transfer watchdog counting clock cycles while a transfer runs
`include "epc_map.svh"
`default_nettype none

module epc_wdog
    import epc_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // control
    input  wire logic run_i,
    output logic      expired_o
);

    localparam logic [`EPC_WDOG_W-1:0] LIMIT = `EPC_WDOG_W'(`EPC_WDOG_CYCLES);

    logic [`EPC_WDOG_W-1:0] cnt_reg;
    logic [`EPC_WDOG_W-1:0] cnt_next;
    wire                    at_limit = (cnt_reg == LIMIT);

    assign cnt_next = !run_i ? '0 : (at_limit ? cnt_reg : cnt_reg + 1'b1);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg   <= '0;
            expired_o <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            expired_o <= run_i && (cnt_next == LIMIT);
        end
    end

endmodule : epc_wdog

`default_nettype wire

// File: testbench/epc_periph_model.sv
// peripheral model on the far side of the parallel cable
`default_nettype none

module epc_periph_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // cable side
    input  wire logic        strobe_n_i,
    input  wire logic        oe_i,
    input  wire logic [7:0]  bus_i,
    output logic             wait_n_o,
    output logic [7:0]       bus_o,
    // bench side
    input  wire logic [15:0] delay_i,
    input  wire logic [7:0]  rdata_i,
    output logic [7:0]       got_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_reg;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg  <= 16'h0000;
            wait_n_o <= 1'b0;
            bus_o    <= 8'h5a;
            got_o    <= 8'h00;
        end else if (!strobe_n_i) begin
            cnt_reg <= cnt_reg + 16'h0001;
            bus_o   <= oe_i ? ~bus_o : rdata_i;
            if (cnt_reg >= delay_i) begin
                wait_n_o <= 1'b1;
                if (oe_i) begin
                    got_o <= bus_i;
                end
            end
        end else begin
            cnt_reg  <= 16'h0000;
            wait_n_o <= 1'b0;
            // released bus shows a changing pattern
            bus_o    <= ~bus_o;
        end
    end
endmodule : epc_periph_model

`default_nettype wire

// File: testbench/epp17_cycle_engine_test.sv
// self-checking bench of the parallel port cycle engine
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end

module epp17_cycle_engine_test
    import epc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, arst_n_i, epp_mode, dir_bit, spp_strobe, init_ctl, to_clr;
    logic        wait_n, periph_interrupt_in, paper, sel, fault_n, periph_interrupt_out, init_n;
    logic        oe, dir_low, ds_n, as_n, host_wait;
    logic [7:0]  status, bus_out, pbus, got, rdata_m;
    logic [15:0] delay;
    epc_req_t    req;
    epc_resp_t   resp;
    int          n_fail, checks;

    epc_cycle_engine epc_cycle_engine_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .host_req_i(req), .host_resp_o(resp), .host_wait_o(host_wait),
        .epp_mode_i(epp_mode), .bus_direction_bit_i(dir_bit), .spp_strobe_i(spp_strobe),
        .periph_init_ctl_i(init_ctl), .timeout_clr_i(to_clr), .status_o(status),
        .par_bus_in_i(oe ? bus_out : pbus), .par_bus_out_o(bus_out), .par_bus_oe_o(oe),
        .dir_out_low_o(dir_low), .data_strobe_n_o(ds_n), .addr_strobe_n_o(as_n),
        .periph_wait_n_i(wait_n), .periph_interrupt_i(periph_interrupt_in),
        .periph_interrupt_o(periph_interrupt_out), .periph_init_n_o(init_n),
        .paper_out_status_i(paper), .selected_status_i(sel), .fault_status_n_i(fault_n));

    epc_periph_model epc_periph_model_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .strobe_n_i(ds_n & as_n), .oe_i(oe), .bus_i(bus_out), .wait_n_o(wait_n),
        .bus_o(pbus), .delay_i(delay), .rdata_i(rdata_m), .got_o(got));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // one host transfer, judged when the ready sync comes back
    task automatic xfer(input logic wr, input logic [2:0] ofs, input logic [7:0] wd,
                        input logic [1:0] strb, input logic [7:0] exp_rd, input logic exp_to);
        int         n;
        logic [1:0] seen;
        logic       bad;
        n = 0;
        seen = 2'b00;
        bad = 1'b0;
        @(negedge clk_i);
        req <= '{1'b1, wr, ofs, wd};
        do begin
            @(negedge clk_i);
            req <= '0;
            n++;
            seen |= {~as_n, ~ds_n};
            bad |= (~ds_n | ~as_n) & dir_bit & oe;
            bad |= ~resp.done & ~host_wait & (strb != 2'b00);
        end while (!resp.done && n < 1400);
        `CHK(resp.done, 1'b1)
        `CHK(seen, strb)
        `CHK({ds_n, as_n}, 2'b11)
        `CHK(resp.timeout, exp_to)
        `CHK(bad, 1'b0)
        if (!wr) `CHK(resp.rdata, exp_rd)
        if (exp_to) `CHK(n > 1200 && n < 1300, 1'b1)
        else if (strb != 2'b00) `CHK(n > delay, 1'b1)
        if (wr && strb != 2'b00 && !exp_to) begin
            `CHK(bus_out, wd)
            `CHK(got, wd)
        end
    endtask : xfer

    // ********************************
    // scenarios
    // ********************************
    task automatic t_write;
        `CHK({oe, dir_low}, 2'b10)
        delay = 16'd0;
        xfer(1'b1, 3'h4, 8'ha5, 2'b01, 8'h00, 1'b0);
        delay = 16'd6;
        xfer(1'b1, 3'h7, 8'h3c, 2'b01, 8'h00, 1'b0);
        xfer(1'b1, 3'h3, 8'hc3, 2'b10, 8'h00, 1'b0);
    endtask : t_write

    task automatic t_read;
        dir_bit <= 1'b1;
        repeat (2) @(negedge clk_i);
        `CHK({oe, dir_low}, 2'b01)
        rdata_m = 8'h96;
        delay = 16'd3;
        xfer(1'b0, 3'h5, 8'h00, 2'b01, 8'h96, 1'b0);
        rdata_m = 8'h69;
        delay = 16'd0;
        xfer(1'b0, 3'h3, 8'h00, 2'b10, 8'h69, 1'b0);
    endtask : t_read

    task automatic t_unmapped;
        xfer(1'b0, 3'h2, 8'h00, 2'b00, 8'hff, 1'b0);
        epp_mode <= 1'b0;
        xfer(1'b0, 3'h4, 8'h00, 2'b00, 8'hff, 1'b0);
        epp_mode <= 1'b1;
    endtask : t_unmapped

    task automatic t_side;
        periph_interrupt_in <= 1'b1;
        paper <= 1'b1;
        sel <= 1'b1;
        fault_n <= 1'b0;
        init_ctl <= 1'b1;
        spp_strobe <= 1'b1;
        repeat (3) @(negedge clk_i);
        `CHK(periph_interrupt_out, 1'b1)
        `CHK(init_n, 1'b0)
        `CHK(status, 8'h70)
        `CHK({oe, dir_low, ds_n, as_n}, 4'b1011)
        periph_interrupt_in <= 1'b0;
        sel <= 1'b0;
        fault_n <= 1'b1;
        init_ctl <= 1'b0;
        spp_strobe <= 1'b0;
        repeat (2) @(negedge clk_i);
        `CHK({periph_interrupt_out, init_n}, 2'b01)
    endtask : t_side

    task automatic t_timeout;
        dir_bit <= 1'b0;
        repeat (2) @(negedge clk_i);
        `CHK({oe, dir_low}, 2'b10)
        delay = 16'd3000;
        xfer(1'b1, 3'h6, 8'h11, 2'b01, 8'h00, 1'b1);
        @(negedge clk_i);
        `CHK(status[0], 1'b1)
        to_clr <= 1'b1;
        @(negedge clk_i);
        to_clr <= 1'b0;
        @(negedge clk_i);
        `CHK(status[0], 1'b0)
        delay = 16'd0;
    endtask : t_timeout

    initial begin
        {arst_n_i, dir_bit, spp_strobe, init_ctl, to_clr, periph_interrupt_in, paper, sel} = '0;
        {epp_mode, fault_n} = 2'b11;
        req = '0;
        delay = 16'd0;
        rdata_m = 8'h00;
        n_fail = 0;
        checks = 0;
        repeat (2) @(posedge clk_i);
        `CHK(init_n, 1'b0)
        @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        t_write();
        t_read();
        t_unmapped();
        t_side();
        t_timeout();
        report_and_stop();
    end

    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end
endmodule : epp17_cycle_engine_test

`default_nettype wire
